// *** logic/usb_error_interrupt_logic.v ***
// usb error flags, error enables, turnaround time-out and bus idle detection with an axi4-lite slave
`timescale 1ns/1ps
`include "usb_error_regs.vh"
module usb_error_interrupt_logic #(
    parameter [31:0] IDLE_CYCLES = `IDLE_CYCLES
) (
    input wire aclk,
    input wire aresetn,
    // axi4-lite slave
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // detector strobes from the serial engine, same clock
    input wire bitstuff_err_det,
    input wire datafield_size_err_det,
    input wire data_crc_fail_det,
    input wire token_crc_err_det,
    input wire pid_check_fail_det,
    input wire bit_tick,
    input wire eop_seen,
    input wire response_seen,
    // raw bus activity from the transceiver pins
    input wire bus_active_pin,
    // outputs
    output reg top_error_irq_flag,
    output reg token_reject,
    output reg pullup_en,
    output reg suspend_out
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    // software-visible flags, enables and control
    reg [7:0] usb_error_flags_reg;
    reg [7:0] usb_error_flags_next;
    reg [7:0] usb_error_enables_reg;
    reg bus_idle_flag_reg;
    reg bus_idle_flag_next;
    reg top_error_flag_reg;
    reg [1:0] control_reg;

    // timers behind the turnaround and idle flags
    reg [31:0] idle_count_reg;
    reg idle_seen_reg;
    reg bus_active_prev_reg;
    reg turnaround_wait_reg;
    reg [4:0] turnaround_count_reg;
    reg turnaround_expire;
    reg [7:0] error_set;

    // axi write side
    reg aw_held_reg;
    reg [3:0] aw_addr_reg;
    reg w_held_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    wire write_fire;
    wire aw_take;
    wire w_take;
    wire strb0;

    // activity level once it is safe to read
    wire bus_active;

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    // the pin is asynchronous, so nothing reads it before three stages
    pin_sync3 activity_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(bus_active_pin),
        .level_out(bus_active)
    );

    // ----------------------------------------------------------------
    // axi write channel
    // ----------------------------------------------------------------
    // a channel is taken when its valid meets our ready
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    // both halves held and no response pending
    assign write_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign strb0 = w_strb_reg[0];

    // address and data taken in either order, then one response
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_reg && !aw_take;
            s_axi_wready <= !w_held_reg && !w_take;
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (write_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // unaligned places answer with an error and write nothing
                if (aw_addr_reg[1:0] != 2'h0 || aw_addr_reg > `ADDR_CONTROL) begin
                    s_axi_bresp <= `RESP_SLVERR;
                end else begin
                    s_axi_bresp <= `RESP_OKAY;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // axi read channel
    // ----------------------------------------------------------------
    // one read at a time; arready drops while the answer waits
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                if (s_axi_araddr == `ADDR_ERROR_FLAGS) begin
                    s_axi_rdata <= {24'h000000, usb_error_flags_reg & `ERROR_IMPL_MASK};
                end else if (s_axi_araddr == `ADDR_ERROR_ENABLES) begin
                    s_axi_rdata <= {24'h000000, usb_error_enables_reg & `ERROR_IMPL_MASK};
                end else if (s_axi_araddr == `ADDR_STATUS_FLAGS) begin
                    s_axi_rdata <= {27'h0000000, bus_idle_flag_reg, 2'h0,
                        top_error_flag_reg, 1'b0};
                end else if (s_axi_araddr == `ADDR_CONTROL) begin
                    s_axi_rdata <= {30'h00000000, control_reg};
                end else begin
                    // unmapped places read zero with an error
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            // nothing pending: offer the address channel again
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // turnaround time-out
    // ----------------------------------------------------------------
    // counts bit times after an end of packet; the 17th idle bit expires
    always @* begin
        turnaround_expire = turnaround_wait_reg && bit_tick && !response_seen &&
            (turnaround_count_reg == `TURNAROUND_BIT_TIMES);
    end

    // an end of packet arms the counter, a response disarms it
    always @(posedge aclk) begin
        if (!aresetn) begin
            turnaround_wait_reg <= 1'b0;
            turnaround_count_reg <= 5'h00;
        end else if (eop_seen) begin
            turnaround_wait_reg <= 1'b1;
            turnaround_count_reg <= 5'h00;
        end else if (response_seen || turnaround_expire) begin
            turnaround_wait_reg <= 1'b0; // one time-out per packet
            turnaround_count_reg <= 5'h00;
        end else if (turnaround_wait_reg && bit_tick) begin
            turnaround_count_reg <= turnaround_count_reg + 5'h01;
        end
    end

    // ----------------------------------------------------------------
    // error flag update
    // ----------------------------------------------------------------
    // detectors set flags at once, regardless of enables
    always @* begin
        error_set = 8'h00;
        error_set[`BIT_BITSTUFF] = bitstuff_err_det;
        error_set[`BIT_TURNAROUND] = turnaround_expire;
        error_set[`BIT_DATAFIELD] = datafield_size_err_det;
        error_set[`BIT_DATA_CRC] = data_crc_fail_det;
        error_set[`BIT_TOKEN_CRC] = token_crc_err_det;
        error_set[`BIT_PID_CHECK] = pid_check_fail_det;
        // hold unless software clears or a detector sets
        usb_error_flags_next = usb_error_flags_reg;
        // writing zero clears, one is ignored
        if (write_fire && strb0 && aw_addr_reg == `ADDR_ERROR_FLAGS) begin
            usb_error_flags_next = usb_error_flags_reg & w_data_reg[7:0];
        end
        // a set in the clearing cycle wins
        usb_error_flags_next = (usb_error_flags_next | error_set) & `ERROR_IMPL_MASK;
    end

    // ----------------------------------------------------------------
    // bus idle detection
    // ----------------------------------------------------------------
    // any edge of the synchronised activity restarts the quiet timer
    always @(posedge aclk) begin
        if (!aresetn) begin
            idle_count_reg <= 32'h00000000;
            idle_seen_reg <= 1'b0;
            bus_active_prev_reg <= 1'b0;
        end else begin
            bus_active_prev_reg <= bus_active;
            // a change in either direction counts as traffic
            if (bus_active || bus_active != bus_active_prev_reg) begin
                idle_count_reg <= 32'h00000000;
                idle_seen_reg <= 1'b0;
            end else if (idle_count_reg < IDLE_CYCLES) begin
                idle_count_reg <= idle_count_reg + 32'h00000001;
            end else begin
                idle_seen_reg <= 1'b1; // past the limit: more than 3 ms
            end
        end
    end

    // idle flag sets once per quiet period; set beats a clear
    always @* begin
        bus_idle_flag_next = bus_idle_flag_reg;
        if (write_fire && strb0 && aw_addr_reg == `ADDR_STATUS_FLAGS &&
            !w_data_reg[`BIT_STAT_IDLE]) begin
            bus_idle_flag_next = 1'b0;
        end
        if (idle_count_reg == IDLE_CYCLES && !idle_seen_reg && !bus_active) begin
            bus_idle_flag_next = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // flags every cycle; enables and control only on a full low-byte write
    always @(posedge aclk) begin
        if (!aresetn) begin
            usb_error_flags_reg <= `ERROR_FLAGS_RESET;
            usb_error_enables_reg <= `ERROR_ENABLES_RESET;
            bus_idle_flag_reg <= 1'b0;
            control_reg <= `CONTROL_RESET;
        end else begin
            usb_error_flags_reg <= usb_error_flags_next;
            bus_idle_flag_reg <= bus_idle_flag_next;
            if (write_fire && strb0 && aw_addr_reg == `ADDR_ERROR_ENABLES) begin
                usb_error_enables_reg <= w_data_reg[7:0] & `ERROR_IMPL_MASK;
            end
            if (write_fire && strb0 && aw_addr_reg == `ADDR_CONTROL) begin
                control_reg <= w_data_reg[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // top flag and outputs
    // ----------------------------------------------------------------
    // top flag is derived only, so no write path reaches it
    always @(posedge aclk) begin
        if (!aresetn) begin
            top_error_flag_reg <= 1'b0;
            top_error_irq_flag <= 1'b0;
            token_reject <= 1'b0;
            pullup_en <= 1'b0;
            suspend_out <= 1'b0;
        end else begin
            // both copies lag the masked flags by one cycle
            top_error_flag_reg <= |(usb_error_flags_reg & usb_error_enables_reg);
            top_error_irq_flag <= |(usb_error_flags_reg & usb_error_enables_reg);
            // the token is refused in the cycle after its crc fails
            token_reject <= token_crc_err_det;
            // pull-up ignores suspend and idle, only software removes it
            pullup_en <= control_reg[`BIT_CTRL_PULLUP];
            suspend_out <= control_reg[`BIT_CTRL_SUSPEND];
        end
    end
endmodule

// *** logic/usb_error_regs.vh ***
// register map, field positions, reset values and timing counts of the usb error block
// Functional notes
// - The top error flag is the OR of every error flag, each ANDed with its own enable.
// - Each error flag is set in the cycle its detector reports, not at the end of the token.
// - A set error flag stays set until software writes a zero into its bit position.
// - A bit stuff violation in received data sets the bit stuff flag at bit 7.
// - More than 16 bit times of idle after an end of packet with no response set the turnaround flag at bit 4.
// - A data field that is not a whole number of bytes sets the data field size flag at bit 3.
// - A failed 16-bit data CRC sets the data CRC flag at bit 2, and passing checks leave it clear.
// - A token with a bad 5-bit CRC is rejected and the token CRC flag at bit 1 is set.
// - A failed PID check field comparison sets the PID check flag at bit 0.
// - Each error source has an enable at the same bit position, letting that flag reach the top flag.
// - Error flags are set regardless of their enables, so software may poll them.
// - No bus traffic for more than 3 ms sets the bus idle flag, which signals suspend.
// - The data-line pull-up stays enabled through suspend and bus idle.
// - The top error flag is status only, follows the masked flags and ignores writes.
`ifndef USB_ERROR_REGS_VH
`define USB_ERROR_REGS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADDR_ERROR_FLAGS   4'h0
`define ADDR_ERROR_ENABLES 4'h4
`define ADDR_STATUS_FLAGS  4'h8
`define ADDR_CONTROL       4'hc

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_BITSTUFF   7
`define BIT_TURNAROUND 4
`define BIT_DATAFIELD  3
`define BIT_DATA_CRC   2
`define BIT_TOKEN_CRC  1
`define BIT_PID_CHECK  0
`define ERROR_IMPL_MASK 8'h9f
`define BIT_STAT_IDLE  4
`define BIT_STAT_TOPERR 1
`define BIT_CTRL_PULLUP 0
`define BIT_CTRL_SUSPEND 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ERROR_FLAGS_RESET   8'h00
`define ERROR_ENABLES_RESET 8'h00
`define CONTROL_RESET       2'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ 25000000
`define IDLE_TIME_US 3000
`define IDLE_CYCLES ((`IDLE_TIME_US * (`CLK_HZ / 1000000)))
`define TURNAROUND_BIT_TIMES 16

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// *** logic/pin_sync3.v ***
// three-stage pin synchroniser that passes a level once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 (
    input wire aclk,
    input wire aresetn,
    input wire pin_in,
    output reg level_out
);
    reg stage1_reg;
    reg stage2_reg;
    reg stage3_reg;

    // stage one is only ever read by stage two, to contain metastability
    always @(posedge aclk) begin
        if (!aresetn) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
            level_out <= 1'b0;
        end else begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            if (stage2_reg == stage3_reg) begin
                level_out <= stage3_reg; // filters a one-cycle glitch
            end
        end
    end
endmodule

// *** dv/usb_error_properties.sv ***
// concurrent checks on the ports of the usb error block
`timescale 1ns/1ps
module usb_error_checker #(
    parameter [31:0] IDLE_CYCLES = 32'd75000
) (
    input logic aclk,
    input logic aresetn,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_bvalid,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic [31:0] s_axi_rdata,
    input logic bitstuff_err_det,
    input logic datafield_size_err_det,
    input logic data_crc_fail_det,
    input logic token_crc_err_det,
    input logic pid_check_fail_det,
    input logic bit_tick,
    input logic top_error_irq_flag,
    input logic token_reject,
    input logic pullup_en,
    input logic suspend_out
);
    // --------------------------------
    // helpers and properties
    // --------------------------------
    logic ev;
    // anything that may set an error flag; the tick covers the turnaround count
    assign ev = bitstuff_err_det | datafield_size_err_det | data_crc_fail_det | token_crc_err_det
        | pid_check_fail_det | bit_tick;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_token_reject; token_crc_err_det |=> token_reject; endproperty
    a_token_reject: assert property (p_token_reject) else $error("token not rejected");
    property p_reject_cause; token_reject |-> $past(token_crc_err_det); endproperty
    a_reject_cause: assert property (p_reject_cause) else $error("reject without crc error");
    property p_top_rise; $rose(top_error_irq_flag) |-> $past(ev, 2) || $past(s_axi_bvalid); endproperty
    a_top_rise: assert property (p_top_rise) else $error("top flag rose without cause");
    property p_top_fall; $fell(top_error_irq_flag) |-> $past(s_axi_bvalid); endproperty
    a_top_fall: assert property (p_top_fall) else $error("top flag fell without a write");
    property p_pullup; $changed(pullup_en) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2); endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up moved without a write");
    property p_unimpl; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[6:5] == 2'h0; endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bits read nonzero");
    property p_aw_busy; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
    a_aw_busy: assert property (p_aw_busy) else $error("awready stayed high after take");
    property p_read; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_read: assert property (p_read) else $error("read answer late");
    cover property (top_error_irq_flag);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property (suspend_out && pullup_en);
    cover property (token_reject);
endmodule

bind usb_error_interrupt_logic usb_error_checker #(.IDLE_CYCLES(IDLE_CYCLES)) chk (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rdata, .bitstuff_err_det, .datafield_size_err_det, .data_crc_fail_det,
    .token_crc_err_det, .pid_check_fail_det, .bit_tick, .top_error_irq_flag, .token_reject,
    .pullup_en, .suspend_out);

// *** dv/usb_engine_model.sv ***
// model of the serial engine and transceiver in front of the error block
`timescale 1ns/1ps
module usb_engine_model (
    input logic aclk,
    output logic [4:0] det,
    output logic bit_tick,
    output logic eop_seen,
    output logic response_seen,
    output logic bus_active_pin
);
    initial begin
        det = 5'h0;
        bit_tick = 1'b0;
        eop_seen = 1'b0;
        response_seen = 1'b0;
        bus_active_pin = 1'b1;
    end
    // one-cycle strobe; det order is bitstuff, datafield, data crc, token crc, pid
    task strobe(input int idx);
        @(posedge aclk);
        det <= 5'h1 << idx;
        @(posedge aclk);
        det <= 5'h0;
    endtask
    // end of packet, optional response, then n bit times spaced two cycles apart
    task turnaround(input int n, input bit respond);
        int k;
        @(posedge aclk);
        eop_seen <= 1'b1;
        @(posedge aclk);
        eop_seen <= 1'b0;
        response_seen <= respond;
        for (k = 0; k < n; k++) begin
            @(posedge aclk);
            response_seen <= 1'b0;
            bit_tick <= 1'b1;
            @(posedge aclk);
            bit_tick <= 1'b0;
        end
    endtask
    // the pin is asynchronous, so it moves away from the clock edge
    task bus(input bit v);
        #7;
        bus_active_pin = v;
    endtask
endmodule

// *** dv/test_usb_error_interrupt_logic.sv ***
// self-checking bench of the usb error block
`timescale 1ns/1ps
`include "usb_error_regs.vh"
module test_usb_error_interrupt_logic;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [3:0] araddr = 4'h0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [4:0] det;
    wire bit_tick, eop_seen, response_seen, bus_active_pin, top, token_reject, pullup_en, suspend_out;
    int errors = 0;
    int check_count = 0;
    int i;
    int bitpos [5] = '{`BIT_BITSTUFF, `BIT_DATAFIELD, `BIT_DATA_CRC, `BIT_TOKEN_CRC, `BIT_PID_CHECK};
    logic [31:0] rd;
    logic [1:0] rs;
    always #20 aclk = ~aclk;
    usb_engine_model eng (.aclk(aclk), .det(det), .bit_tick(bit_tick), .eop_seen(eop_seen),
        .response_seen(response_seen), .bus_active_pin(bus_active_pin));
    // short idle count keeps the run brief
    usb_error_interrupt_logic #(.IDLE_CYCLES(32'd20)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .bitstuff_err_det(det[0]), .datafield_size_err_det(det[1]),
        .data_crc_fail_det(det[2]), .token_crc_err_det(det[3]), .pid_check_fail_det(det[4]),
        .bit_tick(bit_tick), .eop_seen(eop_seen), .response_seen(response_seen),
        .bus_active_pin(bus_active_pin), .top_error_irq_flag(top), .token_reject(token_reject),
        .pullup_en(pullup_en), .suspend_out(suspend_out));
    // --------------------------------
    // checking and bus tasks
    // --------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task timeout;
        errors++;
        $display("CHECK FAILED %0t bus wait timed out", $time);
        final_report();
    endtask
    // each channel is released at the edge its ready is seen
    task axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                check(32'(bresp), 32'(er));
                return;
            end
        end
        timeout();
    endtask
    task axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                return;
            end
        end
        timeout();
    endtask
    task rchk(input logic [3:0] a, input logic [31:0] exp);
        axi_read(a, rd, rs);
        check(rd, exp);
        check(32'(rs), 32'(`RESP_OKAY));
    endtask
    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk(`ADDR_ERROR_FLAGS, 32'h0);
        rchk(`ADDR_ERROR_ENABLES, 32'h0);
        rchk(`ADDR_CONTROL, 32'h0);
        axi_write(`ADDR_ERROR_ENABLES, 32'hff, `RESP_OKAY);
        rchk(`ADDR_ERROR_ENABLES, 32'h9f);
        axi_write(`ADDR_ERROR_ENABLES, 32'h0, `RESP_OKAY);
        // each source polled while masked, then unmasked, then cleared
        for (i = 0; i < 5; i++) begin
            eng.strobe(i);
            @(negedge aclk);
            check(token_reject, 32'(i == 3));
            repeat (3) @(posedge aclk);
            check(top, 1'b0);
            rchk(`ADDR_ERROR_FLAGS, 32'h1 << bitpos[i]);
            axi_write(`ADDR_ERROR_FLAGS, 32'hff, `RESP_OKAY);
            rchk(`ADDR_ERROR_FLAGS, 32'h1 << bitpos[i]);
            axi_write(`ADDR_ERROR_ENABLES, 32'h1 << bitpos[i], `RESP_OKAY);
            axi_write(`ADDR_STATUS_FLAGS, 32'h0, `RESP_OKAY);
            repeat (2) @(posedge aclk);
            check(top, 1'b1);
            rchk(`ADDR_STATUS_FLAGS, 32'h2);
            axi_write(`ADDR_ERROR_FLAGS, 32'h0, `RESP_OKAY);
            repeat (2) @(posedge aclk);
            check(top, 1'b0);
            axi_write(`ADDR_ERROR_ENABLES, 32'h0, `RESP_OKAY);
        end
        // turnaround: exactly 16 quiet bit times, a response, then 17 bit times
        eng.turnaround(16, 1'b0);
        rchk(`ADDR_ERROR_FLAGS, 32'h0);
        eng.turnaround(20, 1'b1);
        rchk(`ADDR_ERROR_FLAGS, 32'h0);
        eng.turnaround(17, 1'b0);
        rchk(`ADDR_ERROR_FLAGS, 32'h10);
        // bus idle with the pull-up on, then suspend
        axi_write(`ADDR_CONTROL, 32'h1, `RESP_OKAY);
        rchk(`ADDR_STATUS_FLAGS, 32'h0);
        eng.bus(1'b0);
        repeat (8) @(posedge aclk);
        rchk(`ADDR_STATUS_FLAGS, 32'h0);
        repeat (40) @(posedge aclk);
        rchk(`ADDR_STATUS_FLAGS, 32'h10);
        axi_write(`ADDR_CONTROL, 32'h3, `RESP_OKAY);
        repeat (5) @(posedge aclk);
        check({suspend_out, pullup_en}, 2'h3);
        // misaligned places are refused and change nothing
        axi_read(4'h2, rd, rs);
        check(32'(rs), 32'(`RESP_SLVERR));
        check(rd, 32'h0);
        axi_write(4'h6, 32'hff, `RESP_SLVERR);
        rchk(`ADDR_ERROR_ENABLES, 32'h0);
        final_report();
    end
endmodule
